// ===== hdl/pcmsp_activity.sv
// Decides whether a dual-use pin carries a clock or a static level.
// Assumes the pin is already synchronous to clk_sys.
`timescale 1ns/1ps
module pcmsp_activity
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic clk_en,
    // Watched pin
    pcmsp_act_if.det  port
);
    typedef struct packed {
        logic                           prev;
        logic [pcmsp_pkg::ACT_CNT_W-1:0] idle;
        logic                           active;
    } pcmsp_act_st_t;

    pcmsp_act_st_t s_reg;
    pcmsp_act_st_t s_next;

    // Any edge restarts the window; silence for the whole window means static
    always_comb
    begin
        s_next      = s_reg;
        s_next.prev = port.pin;
        if (port.pin != s_reg.prev)
        begin
            s_next.idle   = '0;
            s_next.active = 1'b1;
        end
        else if (s_reg.idle == pcmsp_pkg::ACT_CNT_W'(pcmsp_pkg::ACT_WINDOW_CYC))
            s_next.active = 1'b0;
        else
            s_next.idle = s_reg.idle + 1'b1;
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else if (clk_en)
            s_reg <= s_next;
    end

    assign port.active = s_reg.active;
    assign port.level  = s_reg.prev;
endmodule

// ===== hdl/pcmsp_pd_timer.sv
// Counts master clock ticks since the last frame sync pulse.
// Assumes tick is a one-cycle pulse per selected master clock period.
`timescale 1ns/1ps
module pcmsp_pd_timer
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic clk_en,
    // Timer port
    pcmsp_tmr_if.tmr  port
);
    typedef struct packed {
        logic [pcmsp_pkg::PD_CNT_W-1:0] cnt;
        logic                          expired;
    } pcmsp_tmr_st_t;

    pcmsp_tmr_st_t s_reg;
    pcmsp_tmr_st_t s_next;

    // Clear wins over tick so a fresh pulse always restarts the interval
    always_comb
    begin
        s_next = s_reg;
        if (port.clear)
        begin
            s_next.cnt     = '0;
            s_next.expired = 1'b0;
        end
        else if (port.tick && !s_reg.expired)
        begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_next.cnt >= port.limit)
                s_next.expired = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else if (clk_en)
            s_reg <= s_next;
    end

    assign port.expired = s_reg.expired;
endmodule

// ===== hdl/pcmsp_top.sv
// Digital side of a companding PCM voice codec: power control, clock
// routing, rate selection and short- or long-frame serial transfer.
// Assumes all pins, bit clocks and master clocks are slow against clk_sys
// and synchronous to it, so each is sampled as plain data.
`timescale 1ns/1ps
module pcmsp_top
#(
    parameter bit MU_LAW = 1'b0
)
(
    // Clock, reset and clock enable
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Master and bit clock pins
    input  wire logic       tx_master_clock,
    input  wire logic       rx_master_clock_or_powerdown,
    input  wire logic       tx_bit_clock,
    input  wire logic       rx_bit_clock_or_rate_select,
    // Frame syncs and serial data
    input  wire logic       tx_frame_sync,
    input  wire logic       rx_frame_sync,
    input  wire logic       rx_pcm_in,
    output logic            tx_pcm_out,
    output logic            tx_pcm_out_en,
    // Open-drain encoder slot strobe
    output logic            encoder_slot_strobe_out,
    output logic            encoder_slot_strobe_oe,
    // Encoder and decoder codes
    input  wire logic [7:0] tx_code,
    output logic [7:0]      rx_code,
    output logic            rx_code_valid,
    // Analog control and status
    input  wire logic       analog_loopback_ctrl,
    output logic            tx_filter_from_rx_amp,
    output logic            receive_filter_output_en,
    output logic            power_amp_enable,
    output logic            powered_up,
    output logic            long_frame_mode,
    output logic            master_rate_2048,
    output logic            rx_uses_tx_master,
    output logic            rx_uses_tx_bit,
    output logic            filter_clock_tick
);
    typedef struct packed {
        logic                       txb_prev;
        logic                       rxb_prev;
        logic                       mck_prev;
        logic                       txfs_prev;
        logic                       rxfs_prev;
        logic                       powered;
        pcmsp_pkg::pcmsp_tx_state_t tx_state;
        logic [3:0]                 tx_cnt;
        logic [7:0]                 tx_sh;
        logic [7:0]                 tx_hold;
        logic                       tx_out;
        logic                       tx_slot;
        logic                       tx_drive;
        logic [1:0]                 tx_fs_cnt;
        logic                       long_mode;
        logic [1:0]                 fs_len;
        pcmsp_pkg::pcmsp_rx_state_t rx_state;
        logic [3:0]                 rx_cnt;
        logic [7:0]                 rx_sh;
        logic [7:0]                 rx_code;
        logic                       rx_valid;
        logic [7:0]                 frame_mclk;
        logic [2:0]                 div_cnt;
        logic                       filt_tick;
    } pcmsp_top_st_t;

    pcmsp_top_st_t s_reg;
    pcmsp_top_st_t s_next;

    // Pin watchers: index 0 is the receive master clock, 1 the rate select
    pcmsp_act_if act [2] ();
    pcmsp_tmr_if tmr ();

    assign act[0].pin = rx_master_clock_or_powerdown;
    assign act[1].pin = rx_bit_clock_or_rate_select;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_act
            pcmsp_activity u_act
            (
                .clk_sys (clk_sys),
                .rst     (rst),
                .clk_en  (clk_en),
                .port    (act[gi])
            );
        end
    endgenerate

    pcmsp_pd_timer u_tmr
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_en  (clk_en),
        .port    (tmr)
    );

    logic use_tx_master;
    logic use_tx_bit;
    logic pd_pin;
    logic rate_hi;
    logic mck_sel;
    logic rxb_sel;
    logic mck_rise;
    logic txb_rise;
    logic txb_fall;
    logic rxb_fall;
    logic txfs_rise;
    logic rxfs_rise;
    logic absorb;
    logic rate_pin_hi;

    // Clock routing: a static pin hands its job to the transmit clock
    assign use_tx_master = !act[0].active;
    assign use_tx_bit    = !act[1].active;
    assign pd_pin        = use_tx_master && act[0].level;
    // Clocked or high picks the fast rate on A-law; mu-law is the inverse
    assign rate_pin_hi   = act[1].active || act[1].level;
    assign rate_hi       = MU_LAW ? !rate_pin_hi : rate_pin_hi;

    assign mck_sel = use_tx_master ? tx_master_clock
                                   : rx_master_clock_or_powerdown;
    assign rxb_sel = use_tx_bit ? tx_bit_clock
                                : rx_bit_clock_or_rate_select;

    // Edge detectors on sampled pins
    assign mck_rise  = mck_sel && !s_reg.mck_prev;
    assign txb_rise  = tx_bit_clock && !s_reg.txb_prev;
    assign txb_fall  = !tx_bit_clock && s_reg.txb_prev;
    assign rxb_fall  = !rxb_sel && s_reg.rxb_prev;
    assign txfs_rise = tx_frame_sync && !s_reg.txfs_prev;
    assign rxfs_rise = rx_frame_sync && !s_reg.rxfs_prev;

    // Skip master clock pulses beyond 192 in a low-rate frame
    assign absorb = !rate_hi
                 && (s_reg.frame_mclk >= pcmsp_pkg::MCLK_PER_FRAME_LO);

    // Power-down interval: restarted by any sync, held clear while down
    assign tmr.tick  = mck_rise;
    assign tmr.clear = txfs_rise || rxfs_rise || !s_reg.powered;
    assign tmr.limit = rate_hi ? pcmsp_pkg::PD_CNT_HI
                               : pcmsp_pkg::PD_CNT_LO;

    // Next-state logic
    always_comb
    begin
        s_next           = s_reg;
        s_next.txb_prev  = tx_bit_clock;
        s_next.rxb_prev  = rxb_sel;
        s_next.mck_prev  = mck_sel;
        s_next.txfs_prev = tx_frame_sync;
        s_next.rxfs_prev = rx_frame_sync;
        s_next.rx_valid  = 1'b0;
        s_next.filt_tick = 1'b0;

        // Power control; the pin wins over a sync arriving together
        if (pd_pin)
            s_next.powered = 1'b0;
        else if (txfs_rise || rxfs_rise)
            s_next.powered = 1'b1;
        else if (s_reg.powered && tmr.expired)
            s_next.powered = 1'b0;

        // Internal filter clock divider with 193rd pulse absorption
        if (txfs_rise)
            s_next.frame_mclk = '0;
        else if (mck_rise && s_reg.frame_mclk != 8'hff)
            s_next.frame_mclk = s_reg.frame_mclk + 1'b1;
        if (mck_rise && !absorb)
        begin
            if (s_reg.div_cnt == (rate_hi ? pcmsp_pkg::DIV_LAST_HI
                                          : pcmsp_pkg::DIV_LAST_LO))
            begin
                s_next.div_cnt   = '0;
                s_next.filt_tick = 1'b1;
            end
            else
                s_next.div_cnt = s_reg.div_cnt + 1'b1;
        end

        // Frame sync length decides short or long framing
        if (txb_fall)
        begin
            if (tx_frame_sync)
            begin
                if (s_reg.fs_len != pcmsp_pkg::LONG_FS_BITS)
                    s_next.fs_len = s_reg.fs_len + 1'b1;
                if (s_next.fs_len == pcmsp_pkg::LONG_FS_BITS)
                    s_next.long_mode = 1'b1;
            end
            else
            begin
                if (s_reg.fs_len != 2'h0
                    && s_reg.fs_len != pcmsp_pkg::LONG_FS_BITS)
                    s_next.long_mode = 1'b0;
                s_next.fs_len = '0;
            end
        end

        // Transmit: a sync seen on a falling edge arms; the next rising edge opens the slot
        unique case (s_reg.tx_state)
            pcmsp_pkg::TX_IDLE:
            begin
                if (txb_fall && tx_frame_sync && s_reg.fs_len == 2'h0
                    && s_reg.powered)
                begin
                    // Previous code goes out, the new one waits a frame
                    s_next.tx_sh    = s_reg.tx_hold;
                    s_next.tx_hold  = tx_code;
                    s_next.tx_state = pcmsp_pkg::TX_ARMED;
                    if (s_reg.tx_fs_cnt != 2'h2)
                        s_next.tx_fs_cnt = s_reg.tx_fs_cnt + 1'b1;
                end
            end
            pcmsp_pkg::TX_ARMED:
            begin
                if (txb_rise)
                begin
                    s_next.tx_out   = s_reg.tx_sh[7];
                    s_next.tx_sh    = {s_reg.tx_sh[6:0], 1'b0};
                    s_next.tx_cnt   = 4'h1;
                    s_next.tx_slot  = 1'b1;
                    s_next.tx_drive = (s_reg.tx_fs_cnt == 2'h2);
                    s_next.tx_state = pcmsp_pkg::TX_SHIFT;
                end
            end
            pcmsp_pkg::TX_SHIFT:
            begin
                if (txb_rise && s_reg.tx_cnt != pcmsp_pkg::PCM_BITS)
                begin
                    s_next.tx_out = s_reg.tx_sh[7];
                    s_next.tx_sh  = {s_reg.tx_sh[6:0], 1'b0};
                    s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
                end
                else if (txb_fall && s_reg.tx_cnt == pcmsp_pkg::PCM_BITS)
                begin
                    // Falling edge after the eighth bit ends the slot
                    s_next.tx_slot  = 1'b0;
                    s_next.tx_drive = 1'b0;
                    s_next.tx_state = pcmsp_pkg::TX_IDLE;
                    if (tx_frame_sync && s_reg.fs_len == 2'h0 && s_reg.powered)
                    begin
                        s_next.tx_sh    = s_reg.tx_hold;
                        s_next.tx_hold  = tx_code;
                        s_next.tx_state = pcmsp_pkg::TX_ARMED;
                        if (s_reg.tx_fs_cnt != 2'h2)
                            s_next.tx_fs_cnt = s_reg.tx_fs_cnt + 1'b1;
                    end
                end
            end
            default:
                s_next.tx_state = pcmsp_pkg::TX_IDLE;
        endcase

        // Receive: sync on a falling edge, then eight capturing edges
        unique case (s_reg.rx_state)
            pcmsp_pkg::RX_IDLE:
            begin
                if (rxb_fall && rx_frame_sync && s_reg.powered)
                begin
                    s_next.rx_cnt   = '0;
                    s_next.rx_state = pcmsp_pkg::RX_SHIFT;
                end
            end
            pcmsp_pkg::RX_SHIFT:
            begin
                if (rxb_fall)
                begin
                    s_next.rx_sh  = {s_reg.rx_sh[6:0], rx_pcm_in};
                    s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
                    if (s_next.rx_cnt == pcmsp_pkg::PCM_BITS)
                    begin
                        s_next.rx_code  = s_next.rx_sh;
                        s_next.rx_valid = 1'b1;
                        s_next.rx_state = pcmsp_pkg::RX_IDLE;
                    end
                end
            end
        endcase

        // Losing power abandons any transfer and rearms the enable count
        if (!s_next.powered)
        begin
            s_next.tx_state  = pcmsp_pkg::TX_IDLE;
            s_next.tx_slot   = 1'b0;
            s_next.tx_drive  = 1'b0;
            s_next.tx_fs_cnt = '0;
            s_next.rx_state  = pcmsp_pkg::RX_IDLE;
        end
    end

    // State register; reset gives powered down and short framing
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_reg         <= '0;
            s_reg.powered <= pcmsp_pkg::PWR_RESET;
        end
        else if (clk_en)
            s_reg <= s_next;
    end

    // Serial pins; the strobe only ever sinks current
    assign tx_pcm_out              = s_reg.tx_out;
    assign tx_pcm_out_en           = s_reg.tx_drive;
    assign encoder_slot_strobe_out = 1'b0;
    assign encoder_slot_strobe_oe  = s_reg.tx_slot;

    // Decoder code and status
    assign rx_code                  = s_reg.rx_code;
    assign rx_code_valid            = s_reg.rx_valid;
    assign receive_filter_output_en = s_reg.powered;
    assign power_amp_enable         = s_reg.powered;
    assign powered_up               = s_reg.powered;
    assign long_frame_mode          = s_reg.long_mode;
    assign master_rate_2048         = rate_hi;
    assign rx_uses_tx_master        = use_tx_master;
    assign rx_uses_tx_bit           = use_tx_bit;
    assign filter_clock_tick        = s_reg.filt_tick;
    // Loopback switch follows the pin directly; low means normal path
    assign tx_filter_from_rx_amp    = analog_loopback_ctrl;
endmodule

// ===== pkg/pcmsp_if.sv
// Carriers between the serial port top and its helper modules.
// Assumes all members are driven and read in the clk_sys domain.
`timescale 1ns/1ps

// Clock-or-level pin watcher
interface pcmsp_act_if;
    logic pin;
    logic active;
    logic level;
    modport det  (input pin, output active, output level);
    modport user (output pin, input active, input level);
endinterface

// Power-down interval timer
interface pcmsp_tmr_if;
    logic                          tick;
    logic                          clear;
    logic [pcmsp_pkg::PD_CNT_W-1:0] limit;
    logic                          expired;
    modport tmr  (input tick, input clear, input limit, output expired);
    modport user (output tick, output clear, output limit, input expired);
endinterface

// ===== pkg/pcmsp_pkg.sv
// Shared constants and state types for the PCM codec serial port.
// Assumes every pin is sampled on clk_sys at 125 MHz.
package pcmsp_pkg;

    // System clock rate
    localparam int CLK_SYS_MHZ = 125;

    // A pin that has not toggled for this long counts as a static level
    localparam int ACT_WINDOW_NS  = 20000;
    localparam int ACT_WINDOW_CYC = (ACT_WINDOW_NS * CLK_SYS_MHZ + 999) / 1000;
    localparam int ACT_CNT_W      = 12;

    // Automatic power-down interval, counted in master clock periods
    localparam int PD_TIME_US   = 2000;
    localparam int MCLK_HI_KHZ  = 2048;
    localparam int MCLK_LO_KHZ  = 1544;
    localparam int PD_CNT_W     = 13;
    localparam logic [PD_CNT_W-1:0] PD_CNT_HI =
        PD_CNT_W'(PD_TIME_US * MCLK_HI_KHZ / 1000);
    localparam logic [PD_CNT_W-1:0] PD_CNT_LO =
        PD_CNT_W'(PD_TIME_US * MCLK_LO_KHZ / 1000);

    // Internal filter clock division; low rate frames carry 192 + 1 pulses
    localparam logic [7:0] MCLK_PER_FRAME_LO = 8'hc0;
    localparam logic [2:0] DIV_LAST_HI       = 3'h7;
    localparam logic [2:0] DIV_LAST_LO       = 3'h5;

    // Serial framing
    localparam logic [3:0] PCM_BITS     = 4'h8;
    localparam logic [1:0] LONG_FS_BITS = 2'h3;

    // Reset value of the power state: powered down
    localparam logic PWR_RESET = 1'b0;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_ARMED,
        TX_SHIFT
    } pcmsp_tx_state_t;

    typedef enum logic {
        RX_IDLE,
        RX_SHIFT
    } pcmsp_rx_state_t;

endpackage

// ===== verification/pcmsp_assertions.sv
// Pin-level checks on the serial port top.
// Assumes it is bound into pcmsp_top and sees only its ports.
`timescale 1ns/1ps
module pcmsp_assertions
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Clock and sync pins
    input wire logic tx_master_clock,
    input wire logic rx_master_clock_or_powerdown,
    input wire logic tx_bit_clock,
    input wire logic tx_frame_sync,
    input wire logic rx_frame_sync,
    // Watched outputs
    input wire logic tx_pcm_out_en,
    input wire logic encoder_slot_strobe_oe,
    input wire logic rx_code_valid,
    input wire logic powered_up,
    input wire logic master_rate_2048,
    input wire logic rx_uses_tx_master
);
    logic [3:0]  n_rise;
    logic [12:0] n_mclk;
    logic [12:0] lim;

    // Expiry figure follows the rate in force
    assign lim = master_rate_2048 ? pcmsp_pkg::PD_CNT_HI
                                  : pcmsp_pkg::PD_CNT_LO;

    // Bit rises within a slot; master rises since the last sync rise
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            n_rise <= 4'h0;
            n_mclk <= 13'h0000;
        end
        else
        begin
            n_rise <= tx_pcm_out_en ? n_rise + 4'($rose(tx_bit_clock)) : 4'h0;
            if ($rose(tx_frame_sync) || $rose(rx_frame_sync))
                n_mclk <= 13'h0000;
            else
                n_mclk <= n_mclk + 13'($rose(tx_master_clock));
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // A sync rise; the power-down pin known static high
    sequence s_sync_up;
        $rose(tx_frame_sync) || $rose(rx_frame_sync);
    endsequence
    sequence s_pin_high;
        rx_uses_tx_master && rx_master_clock_or_powerdown;
    endsequence

    property p_up;
        s_sync_up ##0 !(rx_uses_tx_master && rx_master_clock_or_powerdown)
            |=> powered_up;
    endproperty
    property p_pin_down;
        s_pin_high ##1 s_pin_high |=> !powered_up;
    endproperty
    property p_quiet;
        !powered_up ##1 !powered_up |-> !tx_pcm_out_en;
    endproperty
    property p_strobe;
        tx_pcm_out_en |-> encoder_slot_strobe_oe;
    endproperty
    property p_on_rise;
        $rose(tx_pcm_out_en)
            |-> $past(tx_bit_clock) && !$past(tx_bit_clock, 3);
    endproperty
    property p_eight;
        $fell(tx_pcm_out_en) && powered_up |-> n_rise == 4'h7;
    endproperty
    property p_rx_fall;
        rx_code_valid |-> !tx_bit_clock && $past(tx_bit_clock, 3)
            ##1 !rx_code_valid;
    endproperty
    property p_auto;
        $fell(powered_up) && rx_uses_tx_master && !rx_master_clock_or_powerdown
            |-> n_mclk >= lim - 13'h1 && n_mclk <= lim + 13'h1;
    endproperty

    a_up: assert property (p_up)
        else $error("no power-up");
    a_pin_down: assert property (p_pin_down)
        else $error("pin did not power down");
    a_quiet: assert property (p_quiet)
        else $error("data driven while down");
    a_strobe: assert property (p_strobe)
        else $error("strobe missing in slot");
    a_on_rise: assert property (p_on_rise)
        else $error("enable not on a bit rise");
    a_eight: assert property (p_eight)
        else $error("slot length wrong");
    a_rx_fall: assert property (p_rx_fall)
        else $error("code not after a falling edge");
    a_auto: assert property (p_auto)
        else $error("auto power-down count wrong");
endmodule

bind pcmsp_top pcmsp_assertions u_pcmsp_assertions (.*);

// ===== verification/pcmsp_partner.sv
// Far-side highway model: clocks, frame syncs and receive data.
// Assumes a frame of 128 clk_sys cycles; pins move on falling clk_sys.
`timescale 1ns/1ps
module pcmsp_partner
(
    // Clock and controls
    input  wire logic       clk_sys,
    input  wire logic       run,
    input  wire logic       lng,
    input  wire logic [7:0] rx_byte,
    // Pins and frame position
    output logic            mclk,
    output logic            bclk,
    output logic            fsync,
    output logic            rx_bit,
    output logic [6:0]      pos
);
    logic [6:0] p4;

    initial pos = 7'h00;
    // Clocks and syncs share one counter, so all stay aligned
    always @(negedge clk_sys)
        pos <= pos + 7'h01;
    assign mclk = pos[1];
    assign bclk = pos[2];
    // One pulse a frame around a falling bit edge
    assign fsync = run && (pos >= 7'h7c || pos < (lng ? 7'h14 : 7'h04));
    // Code MSB first; a toggling pattern once released
    assign p4 = pos + 7'h04;
    assign rx_bit = (p4[6:3] != 4'h0 && p4[6:3] <= 4'h8)
                  ? rx_byte[3'(4'h8 - p4[6:3])] : pos[0];
endmodule

// ===== verification/pcmsp_top_tb.sv
// Self-checking bench for the serial port top with a far-side model.
// Assumes clk_sys at 125 MHz; the model frames every 128 cycles.
`timescale 1ns/1ps
module pcmsp_top_tb;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       rmp = 1'b0; // Static low keeps one master clock
    logic       rsel = 1'b1;
    logic       rclk = 1'b0;
    logic       run = 1'b0;
    logic       lng = 1'b0;
    logic       lpb = 1'b0;
    logic [7:0] rxb = 8'h00;
    logic [7:0] txc = 8'h00;
    logic [7:0] cp, got, seed, rcode;
    logic       mclk, bclk, fs, rbit, dx, dx_en, ts_oe;
    logic       lpb_o, up, lfm, r2048, umas, ubit;
    logic       ts_o, rfo, pae, ftk;
    int         n_tick = 0;
    int         t0 = 0;
    logic [6:0] pos;
    int         n_fail = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    `define CHK(n, e, g) chk(n, 8'(e), 8'(g))

    pcmsp_partner u_pcmsp_partner
    (
        .clk_sys(clk_sys), .run(run), .lng(lng), .rx_byte(rxb),
        .mclk(mclk), .bclk(bclk), .fsync(fs), .rx_bit(rbit), .pos(pos)
    );
    pcmsp_top u_pcmsp_top
    (
        .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
        .tx_master_clock(mclk), .rx_master_clock_or_powerdown(rmp),
        .tx_bit_clock(bclk),
        .rx_bit_clock_or_rate_select(rclk ? bclk : rsel),
        .tx_frame_sync(fs), .rx_frame_sync(fs), .rx_pcm_in(rbit),
        .tx_pcm_out(dx), .tx_pcm_out_en(dx_en),
        .encoder_slot_strobe_out(ts_o), .encoder_slot_strobe_oe(ts_oe),
        .tx_code(txc), .rx_code(rcode), .rx_code_valid(),
        .analog_loopback_ctrl(lpb), .tx_filter_from_rx_amp(lpb_o),
        .receive_filter_output_en(rfo), .power_amp_enable(pae),
        .powered_up(up),
        .long_frame_mode(lfm), .master_rate_2048(r2048),
        .rx_uses_tx_master(umas), .rx_uses_tx_bit(ubit),
        .filter_clock_tick(ftk)
    );

    always #4 clk_sys = ~clk_sys;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input string nm, input logic [7:0] ex,
                       input logic [7:0] gt);
        cmp_count++;
        if (gt !== ex)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, ex, gt);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Sample just after the edge so outputs have settled
    task automatic wait_pos(input logic [6:0] p);
        do @(posedge clk_sys); while (pos !== p);
        #1;
    endtask

    // New codes enter mid-frame; the next slot is then checked
    task automatic frame(input int f);
        wait_pos(7'h40);
        @(negedge clk_sys);
        cp = txc;
        seed = lfsr(seed);
        txc = seed;
        seed = lfsr(seed);
        rxb = seed;
        lpb = seed[0];
        lng = (f == 3);
        rclk = (f == 5);
        run = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            wait_pos(7'(7 + 8 * k));
            got = {got[6:0], dx};
            if (k == 0)
            begin
                `CHK("powered", 1, up);
                `CHK("out en", f > 1, dx_en);
                `CHK("strobe", 2, {ts_oe, ts_o});
                `CHK("filter en", 3, {rfo, pae});
            end
        end
        if (f > 1)
            `CHK("tx code", cp, got);
        wait_pos(7'h50);
        `CHK("off en", 0, dx_en);
        `CHK("rx code", rxb, rcode);
        `CHK("long", f == 3, lfm);
        `CHK("uses tx bit", f != 5, ubit);
        `CHK("loopback", lpb, lpb_o);
    endtask

    // Cut a hang short; also count divided filter clock pulses
    always @(posedge clk_sys)
    begin
        cyc++;
        n_tick += ftk;
        if (cyc == 40000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        seed = 8'h07;
        got = 8'h00;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        `CHK("powered", 0, up);
        `CHK("out en", 0, dx_en);
        `CHK("long", 0, lfm);
        `CHK("filter en", 0, {rfo, pae});
        repeat (2600) @(negedge clk_sys);
        `CHK("rate", 1, r2048);
        `CHK("uses tx mclk", 1, umas);
        for (int f = 1; f < 6; f++)
            frame(f);
        @(negedge clk_sys);
        run = 1'b0;
        rclk = 1'b0;
        rsel = 1'b0;
        repeat (3000) @(negedge clk_sys);
        `CHK("rate", 0, r2048);
        `CHK("uses tx bit", 1, ubit);
        // No sync for long at low rate: every further pulse is absorbed
        t0 = n_tick;
        repeat (9000) @(negedge clk_sys);
        `CHK("ticks", 0, n_tick - t0);
        `CHK("powered", 1, up);
        repeat (600) @(negedge clk_sys);
        `CHK("powered", 0, up);
        rmp = 1'b1;
        run = 1'b1;
        repeat (3000) @(negedge clk_sys);
        `CHK("pin down", 0, up);
        rmp = 1'b0;
        repeat (2600) @(negedge clk_sys);
        `CHK("uses tx mclk", 1, umas);
        // Six frames hold 192 master rises, so 32 low-rate filter ticks
        t0 = n_tick;
        repeat (768) @(negedge clk_sys);
        `CHK("ticks", 32, n_tick - t0);
        frame(2);
        frame(2);
        print_verdict();
    end
endmodule
